/* File: logic/rpmn_regs.svh */
// Purpose: Constants for the root port message notify block.
// Assumes: Message codes follow the link protocol message code byte.
// Notes:   Definitions only.
`ifndef RPMN_REGS_SVH
`define RPMN_REGS_SVH

`define RPMN_CFG_W          32
`define RPMN_RID_W          16
`define RPMN_CODE_W         8
`define RPMN_MSG_ASSERT_A   8'h20
`define RPMN_MSG_ASSERT_B   8'h21
`define RPMN_MSG_ASSERT_C   8'h22
`define RPMN_MSG_ASSERT_D   8'h23
`define RPMN_MSG_DEASSERT_A 8'h24
`define RPMN_MSG_DEASSERT_B 8'h25
`define RPMN_MSG_DEASSERT_C 8'h26
`define RPMN_MSG_DEASSERT_D 8'h27
`define RPMN_MSG_ERR_COR    8'h30
`define RPMN_MSG_ERR_NF     8'h31
`define RPMN_MSG_ERR_FATAL  8'h33
`define RPMN_MSG_PM_PME     8'h18
`define RPMN_MSG_TURNOFF    8'h19
`define RPMN_MSG_TO_ACK     8'h1b
`define RPMN_LINK_L0        3'h0
`define RPMN_LINK_L3_RDY    3'h5
`define RPMN_W1C_RST        32'h00000000

`endif

/* File: logic/rpmn_pkg.sv */
// Purpose: Types for the root port message notify block.
// Assumes: Nothing beyond the constants header.
// Notes:   Flags travel together as one packed struct.
package rpmn_pkg;

    typedef struct packed {
        logic       err_cor;
        logic       err_non_fatal;
        logic       err_fatal;
        logic       turnoff_ack;
        logic [3:0] assert_int;
        logic [3:0] deassert_int;
        logic       power_event;
    } rpmn_flags_s;

    typedef enum logic [1:0] {
        RPMN_IDLE    = 2'b00,
        RPMN_SEND_TO = 2'b01,
        RPMN_WAIT_AK = 2'b10,
        RPMN_L3_RDY  = 2'b11
    } rpmn_state_e;

endpackage

/* File: logic/rpmn_notify.sv */
// Purpose: Decode received messages into flags, send turn-off, and hold
//          the write-one-to-clear status bits of the configuration space.
// Assumes: Received messages arrive as one-cycle code plus requester ID.
// Notes:   All inputs except rst are synchronous to core_clk; rst acts asynchronously.
`timescale 1ns/1ps
`include "rpmn_regs.svh"

// Contract
// - Normal config write of 1 clears a W1C bit; only core events and override writes set it.
// - Override write sets each W1C bit whose write data bit is 1.
// - Override write with data 0 leaves bit; non-W1C bits untouched.
// - Raise correctable error flag on received ERR_COR message.
// - Raise non-fatal error flag on received ERR_NONFATAL message.
// - Raise fatal error flag on received ERR_FATAL message.
// - Type flags are valid only together with the message strobe.
// - Present the sixteen-bit requester ID with each decoded message.
// - Low send_turnoff_n makes the root port transmit a turn-off message.
// - Report turn-off acknowledge, then L3 Ready on link power state.
// - Raise turnoff_ack_msg_flag on received PME_TO_Ack message.
// - One flag per INTA to INTD on matching Assert_INTx message.
// - One flag per INTA to INTD on matching Deassert_INTx message.
// - Raise power_event_msg_flag on received power management event.
// - Pulse message-received strobe when a message arrives.
module rpmn_notify #(
    parameter int W1C_W = `RPMN_CFG_W,
    parameter logic [W1C_W-1:0] W1C_MASK = {W1C_W{1'b1}}
) (
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire logic                     rx_msg_valid,
    input  wire logic [`RPMN_CODE_W-1:0]  rx_msg_code,
    input  wire logic [`RPMN_RID_W-1:0]   rx_msg_rid,
    input  wire logic                     cfg_wr_en,
    input  wire logic [W1C_W-1:0]         config_write_data_in,
    input  wire logic                     w1c_override_write,
    input  wire logic [W1C_W-1:0]         core_status_set,
    input  wire logic                     send_turnoff_n,
    input  wire logic                     tx_ready,
    output logic                          tx_turnoff_valid,
    output logic                          msg_received,
    output logic [`RPMN_RID_W-1:0]        msg_data,
    output rpmn_pkg::rpmn_flags_s         msg_flags,
    output logic                          turnoff_ack_msg_flag,
    output logic                          power_event_msg_flag,
    output logic [2:0]                    link_power_state,
    output logic [W1C_W-1:0]              w1c_status
);

    function automatic rpmn_pkg::rpmn_flags_s decode_msg(
        input logic [`RPMN_CODE_W-1:0] code
    );
        rpmn_pkg::rpmn_flags_s f;
        f = '0;
        case (code)
            `RPMN_MSG_ERR_COR:    f.err_cor = 1'b1;
            `RPMN_MSG_ERR_NF:     f.err_non_fatal = 1'b1;
            `RPMN_MSG_ERR_FATAL:  f.err_fatal = 1'b1;
            `RPMN_MSG_TO_ACK:     f.turnoff_ack = 1'b1;
            `RPMN_MSG_ASSERT_A:   f.assert_int[0] = 1'b1;
            `RPMN_MSG_ASSERT_B:   f.assert_int[1] = 1'b1;
            `RPMN_MSG_ASSERT_C:   f.assert_int[2] = 1'b1;
            `RPMN_MSG_ASSERT_D:   f.assert_int[3] = 1'b1;
            `RPMN_MSG_DEASSERT_A: f.deassert_int[0] = 1'b1;
            `RPMN_MSG_DEASSERT_B: f.deassert_int[1] = 1'b1;
            `RPMN_MSG_DEASSERT_C: f.deassert_int[2] = 1'b1;
            `RPMN_MSG_DEASSERT_D: f.deassert_int[3] = 1'b1;
            `RPMN_MSG_PM_PME:     f.power_event = 1'b1;
            default:              f = '0;
        endcase
        return f;
    endfunction

    logic                       msg_received_r;
    logic                       msg_received_nxt;
    logic [`RPMN_RID_W-1:0]     msg_data_r;
    logic [`RPMN_RID_W-1:0]     msg_data_nxt;
    rpmn_pkg::rpmn_flags_s      flags_r;
    rpmn_pkg::rpmn_flags_s      flags_nxt;
    logic [W1C_W-1:0]           w1c_r;
    logic [W1C_W-1:0]           w1c_nxt;
    rpmn_pkg::rpmn_state_e      state_r;
    rpmn_pkg::rpmn_state_e      state_nxt;
    logic [2:0]                 link_r;
    logic [2:0]                 link_nxt;
    logic                       ack_seen;

    // Flags are registered so they line up with the strobe exactly.
    always_comb begin
        msg_received_nxt = rx_msg_valid;
        msg_data_nxt     = rx_msg_valid ? rx_msg_rid : msg_data_r;
        flags_nxt        = rx_msg_valid ? decode_msg(rx_msg_code) : '0;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            msg_received_r <= 1'b0;
            msg_data_r     <= '0;
            flags_r        <= '0;
        end else begin
            msg_received_r <= msg_received_nxt;
            msg_data_r     <= msg_data_nxt;
            flags_r        <= flags_nxt;
        end
    end

    assign msg_received         = msg_received_r;
    assign msg_data             = msg_data_r;
    assign msg_flags            = flags_r;
    assign turnoff_ack_msg_flag = flags_r.turnoff_ack;
    assign power_event_msg_flag = flags_r.power_event;

    // Core set wins over a same-cycle clear so no event is lost.
    always_comb begin
        w1c_nxt = w1c_r;
        if (cfg_wr_en && w1c_override_write) begin
            w1c_nxt = w1c_r | (config_write_data_in & W1C_MASK);
        end else if (cfg_wr_en) begin
            w1c_nxt = w1c_r & ~(config_write_data_in & W1C_MASK);
        end
        w1c_nxt = w1c_nxt | (core_status_set & W1C_MASK);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            w1c_r <= W1C_W'(`RPMN_W1C_RST);
        end else begin
            w1c_r <= w1c_nxt;
        end
    end

    assign w1c_status = w1c_r;

    assign ack_seen = rx_msg_valid && (rx_msg_code == `RPMN_MSG_TO_ACK);

    // Turn-off sequence; a request while one is in flight is ignored.
    always_comb begin
        state_nxt = state_r;
        link_nxt  = link_r;
        case (state_r)
            rpmn_pkg::RPMN_IDLE: begin
                if (!send_turnoff_n) begin
                    state_nxt = rpmn_pkg::RPMN_SEND_TO;
                end
            end
            rpmn_pkg::RPMN_SEND_TO: begin
                if (tx_ready) begin
                    state_nxt = rpmn_pkg::RPMN_WAIT_AK;
                end
            end
            rpmn_pkg::RPMN_WAIT_AK: begin
                if (ack_seen) begin
                    state_nxt = rpmn_pkg::RPMN_L3_RDY;
                end
            end
            rpmn_pkg::RPMN_L3_RDY: begin
                link_nxt = `RPMN_LINK_L3_RDY;
                // Stay until L3 Ready has been shown for one cycle at least.
                if (send_turnoff_n && link_r == `RPMN_LINK_L3_RDY) begin
                    state_nxt = rpmn_pkg::RPMN_IDLE;
                    link_nxt  = `RPMN_LINK_L0;
                end
            end
            default: begin
                state_nxt = rpmn_pkg::RPMN_IDLE;
                link_nxt  = `RPMN_LINK_L0;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= rpmn_pkg::RPMN_IDLE;
            link_r  <= `RPMN_LINK_L0;
        end else begin
            state_r <= state_nxt;
            link_r  <= link_nxt;
        end
    end

    assign tx_turnoff_valid = (state_r == rpmn_pkg::RPMN_SEND_TO);
    assign link_power_state = link_r;

    // All checks share one clock and stay quiet while reset is held.
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);

    strobe_align_a: assert property (
        (msg_flags != '0) |-> msg_received)
        else $error("type flag without strobe");
    one_flag_a: assert property ($onehot0(msg_flags))
        else $error("more than one type flag");
    rid_pass_a: assert property (
        rx_msg_valid |=> (msg_received && msg_data == $past(rx_msg_rid)))
        else $error("requester id not presented");
    cor_decode_a: assert property (
        (rx_msg_valid && rx_msg_code == `RPMN_MSG_ERR_COR)
        |=> (msg_flags.err_cor && msg_received)
        ##1 (!msg_flags.err_cor || msg_received))
        else $error("correctable flag wrong");
    fatal_decode_a: assert property (
        (rx_msg_valid && rx_msg_code == `RPMN_MSG_ERR_FATAL)
        |=> msg_flags.err_fatal)
        else $error("fatal flag missing");
    nf_decode_a: assert property (
        (rx_msg_valid && rx_msg_code == `RPMN_MSG_ERR_NF)
        |=> msg_flags.err_non_fatal)
        else $error("non-fatal flag missing");
    ack_decode_a: assert property (
        (rx_msg_valid && rx_msg_code == `RPMN_MSG_TO_ACK)
        |=> turnoff_ack_msg_flag)
        else $error("turnoff ack flag missing");
    pme_decode_a: assert property (
        (rx_msg_valid && rx_msg_code == `RPMN_MSG_PM_PME)
        |=> power_event_msg_flag)
        else $error("power event flag missing");
    strobe_idle_a: assert property (
        !rx_msg_valid |=> (!msg_received && msg_flags == '0))
        else $error("strobe without message");
    w1c_set_a: assert property (
        (cfg_wr_en && w1c_override_write)
        |=> ((w1c_status & $past(config_write_data_in) & W1C_MASK)
             == ($past(config_write_data_in) & W1C_MASK)))
        else $error("override write did not set bits");
    w1c_clear_a: assert property (
        (cfg_wr_en && !w1c_override_write)
        |=> ((w1c_status & ~$past(core_status_set)
              & $past(config_write_data_in) & W1C_MASK) == '0))
        else $error("normal write did not clear bits");
    w1c_hold_a: assert property (
        (cfg_wr_en && w1c_override_write)
        |=> ((w1c_status & ~$past(config_write_data_in))
             == (($past(w1c_status) | $past(core_status_set))
                 & W1C_MASK & ~$past(config_write_data_in))))
        else $error("override write changed zero bits");
    turnoff_send_a: assert property (
        (state_r == rpmn_pkg::RPMN_IDLE && !send_turnoff_n)
        |=> tx_turnoff_valid)
        else $error("turn-off not sent");
    l3_report_a: assert property (
        (state_r == rpmn_pkg::RPMN_WAIT_AK && ack_seen)
        |=> turnoff_ack_msg_flag ##1 (link_power_state == `RPMN_LINK_L3_RDY))
        else $error("L3 ready not reported");
    int_decode_a: assert property (
        (rx_msg_valid && rx_msg_code == `RPMN_MSG_DEASSERT_D)
        |=> msg_flags.deassert_int[3])
        else $error("deassert flag missing");
    inta_decode_a: assert property (
        (rx_msg_valid && rx_msg_code == `RPMN_MSG_ASSERT_A)
        |=> msg_flags.assert_int[0])
        else $error("assert flag missing");

endmodule

/* File: tb/rpmn_link_model.sv */
// Purpose: Link side stand-in that feeds messages and answers turn-off.
// Assumes: Bench message requests arrive on req_* after falling edges.
// Notes:   Idle code and ID lines show the inverse of the bench request.
`timescale 1ns/1ps
`include "rpmn_regs.svh"
module rpmn_link_model #(
    parameter int          READY_LAG = 2,
    parameter int          ACK_LAG   = 3,
    parameter logic [15:0] ACK_RID   = 16'h0a5c
) (
    input  wire logic        core_clk,
    input  wire logic        req_v,
    input  wire logic [7:0]  req_code,
    input  wire logic [15:0] req_rid,
    input  wire logic        tx_turnoff_valid,
    output logic             rx_msg_valid,
    output logic [7:0]       rx_msg_code,
    output logic [15:0]      rx_msg_rid,
    output logic             tx_ready
);
    int   lag     = 0;
    int   ack_in  = 0;
    logic ack_v   = 1'b0;
    logic ready_r = 1'b0;
    assign tx_ready = ready_r;
    // A slow ready shows that the request is held until it is taken.
    always @(negedge core_clk) begin
        ack_v = (ack_in == 1);
        if (ack_in > 0) ack_in = ack_in - 1;
        if (ready_r) begin
            ready_r = 1'b0;
            ack_in  = ACK_LAG;
        end else if (tx_turnoff_valid) begin
            lag = lag + 1;
            if (lag > READY_LAG) begin
                ready_r  = 1'b1;
                lag      = 0;
            end
        end
    end
    assign rx_msg_valid = req_v | ack_v;
    assign rx_msg_code  = ack_v ? `RPMN_MSG_TO_ACK :
                          (req_v ? req_code : ~req_code);
    assign rx_msg_rid   = ack_v ? ACK_RID : (req_v ? req_rid : ~req_rid);
endmodule

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the root port message notify block.
// Assumes: Inputs change on falling edges; outputs are read there too.
// Notes:   Assert and deassert codes are listed from line D down to A.
`timescale 1ns/1ps
`include "rpmn_regs.svh"
module testbench;
    logic core_clk = 1'b0, rst = 1'b1, req_v = 1'b0, tx_ready;
    logic [7:0] req_code = 8'h00, rx_msg_code;
    logic [15:0] req_rid = 16'h0000, rx_msg_rid, msg_data;
    logic rx_msg_valid, cfg_wr_en = 1'b0, w1c_override_write = 1'b0;
    logic [31:0] config_write_data_in = 32'h0, core_status_set = 32'h0;
    logic [31:0] w1c_status;
    logic send_turnoff_n = 1'b1, tx_turnoff_valid, msg_received;
    logic turnoff_ack_msg_flag, power_event_msg_flag, seen;
    logic [2:0] link_power_state;
    rpmn_pkg::rpmn_flags_s msg_flags;
    logic [14:0] exp_f, flag_vec;
    assign flag_vec = {msg_flags, turnoff_ack_msg_flag, power_event_msg_flag};
    int num_errors = 0, comparisons = 0, n;
    localparam logic [7:0] CODES [14] = '{`RPMN_MSG_ERR_COR,
        `RPMN_MSG_ERR_NF, `RPMN_MSG_ERR_FATAL, `RPMN_MSG_TO_ACK,
        `RPMN_MSG_ASSERT_D, `RPMN_MSG_ASSERT_C, `RPMN_MSG_ASSERT_B,
        `RPMN_MSG_ASSERT_A, `RPMN_MSG_DEASSERT_D, `RPMN_MSG_DEASSERT_C,
        `RPMN_MSG_DEASSERT_B, `RPMN_MSG_DEASSERT_A, `RPMN_MSG_PM_PME, 8'h7e};
    always #20 core_clk = ~core_clk;
    rpmn_link_model u_link (.core_clk(core_clk), .req_v(req_v),
        .req_code(req_code), .req_rid(req_rid),
        .tx_turnoff_valid(tx_turnoff_valid), .rx_msg_valid(rx_msg_valid),
        .rx_msg_code(rx_msg_code), .rx_msg_rid(rx_msg_rid),
        .tx_ready(tx_ready));
    rpmn_notify #(.W1C_W(32), .W1C_MASK(32'h0000ffff)) u_dut (
        .core_clk(core_clk), .rst(rst), .rx_msg_valid(rx_msg_valid),
        .rx_msg_code(rx_msg_code), .rx_msg_rid(rx_msg_rid),
        .cfg_wr_en(cfg_wr_en), .config_write_data_in(config_write_data_in),
        .w1c_override_write(w1c_override_write),
        .core_status_set(core_status_set), .send_turnoff_n(send_turnoff_n),
        .tx_ready(tx_ready), .tx_turnoff_valid(tx_turnoff_valid),
        .msg_received(msg_received), .msg_data(msg_data),
        .msg_flags(msg_flags), .turnoff_ack_msg_flag(turnoff_ack_msg_flag),
        .power_event_msg_flag(power_event_msg_flag),
        .link_power_state(link_power_state), .w1c_status(w1c_status));
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic w1c(logic [31:0] set, logic [31:0] data, logic wr,
                       logic ovr, logic [31:0] exp);
        core_status_set      = set;
        config_write_data_in = data;
        cfg_wr_en            = wr;
        w1c_override_write   = ovr;
        @(negedge core_clk);
        chk("w1c_status", exp, w1c_status);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (2000) @(negedge core_clk);
        num_errors++;
        conclude();
    end
    initial begin
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        repeat (3) begin
            @(negedge core_clk);
            chk("idle flags", 0, {msg_received, msg_flags});
        end
        $display("test reset done");
        // Back-to-back messages, one per cycle, with an unknown code last.
        for (int i = 0; i < 14; i++) begin
            req_v    = 1'b1;
            req_code = CODES[i];
            req_rid  = 16'hc300 + 16'(i);
            @(negedge core_clk);
            chk("strobe", 1, msg_received);
            chk("rid", req_rid, msg_data);
            exp_f = {13'h1000 >> i, 2'b00} | {13'h0, i == 3, i == 12};
            chk("flags", exp_f, flag_vec);
            chk("int flags", exp_f[10:3], flag_vec[10:3]);
            chk("pm flags", exp_f[1:0], flag_vec[1:0]);
        end
        req_v = 1'b0;
        @(negedge core_clk);
        chk("strobe end", 0, {msg_received, msg_flags});
        $display("test messages done");
        w1c(32'h000000f0, 32'h0, 1'b0, 1'b0, 32'h000000f0);
        w1c(32'h0, 32'h00000030, 1'b1, 1'b0, 32'h000000c0);
        w1c(32'h0, 32'hffff0003, 1'b1, 1'b1, 32'h000000c3);
        w1c(32'h0, 32'h0, 1'b1, 1'b1, 32'h000000c3);
        w1c(32'h00000080, 32'h000000c0, 1'b1, 1'b0, 32'h00000083);
        w1c(32'h0, 32'h0, 1'b0, 1'b0, 32'h00000083);
        $display("test w1c done");
        send_turnoff_n = 1'b0;
        seen = 1'b0;
        n = 0;
        while (!(msg_received && turnoff_ack_msg_flag) && n < 30) begin
            @(negedge core_clk);
            seen = seen | tx_turnoff_valid;
            n++;
        end
        chk("ack wait", 1, n < 30);
        chk("turnoff sent", 1, seen);
        chk("ack rid", 16'h0a5c, msg_data);
        @(negedge core_clk);
        chk("l3 ready", `RPMN_LINK_L3_RDY, link_power_state);
        send_turnoff_n = 1'b1;
        n = 0;
        while (link_power_state !== `RPMN_LINK_L0 && n < 10) begin
            @(negedge core_clk);
            n++;
        end
        chk("back to l0", 1, n < 10);
        $display("test turnoff done");
        conclude();
    end
endmodule
